// ### dv/rtc_count_checker_assertions.sv
`timescale 1ns/100ps
module rtc_count_checker (
  input wire clock,
  input wire rst_n,
  input wire [7:0] addr,
  input wire [31:0] wdata,
  input wire wr_stb,
  input wire rd_stb,
  input wire [31:0] rdata,
  input wire counter_clk_pin,
  input wire debug_halt_pin,
  input wire irq
);
  // Shadow of the mask so reads and the interrupt line can be judged against it.
  logic [1:0] mask_q;
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);
  always @(posedge clock) begin
    if (!rst_n) mask_q <= 2'h3;
    else if (wr_stb && addr == 8'h28) mask_q <= wdata[16:15];
  end
  ////////////////////////////////////////////////////////////
  a_rdata_idle: assert property (!rd_stb |=> rdata == 32'h0)
    else $error("read data not zero outside a read");
  a_cfg_resv: assert property (rd_stb && addr == 8'h40 |=> (rdata & 32'hFFFFFCEF) == 32'h0)
    else $error("config reserved bits set");
  a_div_resv: assert property (rd_stb && addr == 8'h80 |=> (rdata & 32'hFFFFF0FF) == 32'h0)
    else $error("prescale reserved bits set");
  a_sts_resv: assert property (rd_stb && addr == 8'h20 |=> (rdata & 32'hFFFE7FFF) == 32'h0)
    else $error("status reserved bits set");
  a_sys_ready: assert property (rd_stb && addr == 8'h00 |=> rdata[18])
    else $error("system ready not shown");
  a_mask_read: assert property (rd_stb && addr == 8'h28 |=>
    rdata == {15'h0, $past(mask_q), 15'h0})
    else $error("mask readback wrong");
  a_masked_irq: assert property (mask_q == 2'h3 |-> !irq)
    else $error("interrupt while fully masked");
  a_irq_match: assert property (rd_stb && addr == 8'h24 |=> (rdata != 32'h0) == $past(irq))
    else $error("masked status disagrees with interrupt");
endmodule // rtc_count_checker
bind rtc_count_core rtc_count_checker rtc_count_checker_i (.clock(clock), .rst_n(rst_n),
  .addr(addr), .wdata(wdata), .wr_stb(wr_stb), .rd_stb(rd_stb), .rdata(rdata),
  .counter_clk_pin(counter_clk_pin), .debug_halt_pin(debug_halt_pin), .irq(irq));

// ### dv/tb_top.sv
`timescale 1ns/100ps
module tb_top;
  logic clock = 1'h0, rst_n = 1'h0, wr_stb = 1'h0, rd_stb = 1'h0, pin = 1'h0, dbg = 1'h0, irq;
  logic [7:0] addr = 8'h00;
  logic [31:0] wdata = 32'h0, rdata, v, w, seed = 32'h41A3;
  logic [7:0] ra [6] = '{8'h50, 8'h60, 8'h70, 8'h80, 8'h40, 8'h28};
  logic [31:0] rv [6] = '{32'h0, 32'hFFFFFFFF, 32'hFFFFFFFF, 32'h0, 32'h0, 32'h18000};
  logic [7:0] wa [4] = '{8'h40, 8'h80, 8'h50, 8'hFC};
  logic [31:0] wm [4] = '{32'h310, 32'hF00, 32'h0, 32'h0};
  int fails = 0, checks_done = 0, k;
  int cnt = 0, act = -1, shd = -1, aact = -1, ashd = -1, sts = 0, pre = 0, div = 0, halt = 0;
  always #25 clock = ~clock;
  rtc_count_core rtc_count_core_i (.clock(clock), .rst_n(rst_n), .addr(addr), .wdata(wdata),
    .wr_stb(wr_stb), .rd_stb(rd_stb), .rdata(rdata), .counter_clk_pin(pin),
    .debug_halt_pin(dbg), .irq(irq));
  ////////////////////////////////////////////////////////////
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    checks_done++;
    if (s !== e) begin
      fails++;
      $display("CHECK FAILED at %0t seen %h expected %h", $time, s, e);
    end
  endtask
  task automatic close_out();
    $display("Checks %0d, mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    addr <= a;
    wdata <= d;
    wr_stb <= 1'h1;
    @(posedge clock);
    wr_stb <= 1'h0;
    #1;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge clock);
    addr <= a;
    rd_stb <= 1'h1;
    @(posedge clock);
    rd_stb <= 1'h0;
    #1 v = rdata;
  endtask
  // Pin pulses are spaced well beyond the synchroniser delay so every edge is seen.
  task automatic tick(input int n);
    repeat (n) begin
      @(posedge clock);
      pin <= 1'h1;
      repeat (6) @(posedge clock);
      pin <= 1'h0;
      repeat (6) @(posedge clock);
      pre = (pre + 1) % (1 << div);
      if (pre == 0 && halt == 0) begin
        if (cnt == act) begin
          cnt = 0;
          act = shd;
          aact = ashd;
        end else cnt++;
        if (cnt == act) sts |= 32'h10000;
        if (cnt == aact) sts |= 32'h8000;
      end
    end
  endtask
  task automatic creset();
    int n;
    wr(8'h00, 32'h4);
    cnt = 0;
    pre = 0;
    act = shd;
    aact = ashd;
    for (n = 0; n < 8; n++) begin
      rd(8'h00);
      if (v[17] === 1'h1) break;
    end
    chk(v[17], 1'h1);
    if (v[17] !== 1'h1) begin
      close_out();
    end
  endtask
  initial begin
    repeat (8) @(posedge clock);
    rst_n <= 1'h1;
    for (k = 0; k < 6; k++) begin
      rd(ra[k]);
      chk(v, rv[k]);
    end
    for (k = 0; k < 4; k++) begin
      w = rnd();
      wr(wa[k], w);
      rd(wa[k]);
      chk(v, w & wm[k]);
    end
    $display("register map test done");
    wr(8'h80, 32'h0);
    wr(8'h40, 32'h200);
    wr(8'h28, 32'h0);
    wr(8'h70, 32'h2);
    wr(8'h60, 32'h3);
    ashd = 2;
    shd = 3;
    creset();
    wr(8'h00, 32'h1);
    rd(8'h00);
    chk(v, 32'h70000);
    for (k = 0; k < 9; k++) begin
      tick(1);
      if (k == 1) begin
        wr(8'h60, 32'h5);
        shd = 5;
      end
      rd(8'h50);
      chk(v, cnt);
    end
    rd(8'h24);
    chk(v, sts);
    chk(irq, 1'h1);
    wr(8'h28, 32'h18000);
    chk(irq, 1'h0);
    wr(8'h20, sts);
    wr(8'h28, 32'h0);
    chk(irq, 1'h0);
    $display("wrap and interrupt test done");
    div = rnd() % 3 + 1;
    wr(8'h80, div << 8);
    creset();
    tick(9);
    rd(8'h50);
    chk(v, cnt);
    div = 0;
    @(posedge clock);
    dbg <= 1'h1;
    halt = 1;
    wr(8'h80, 32'h0);
    creset();
    tick(2);
    rd(8'h50);
    chk(v, cnt);
    wr(8'h40, 32'h210);
    halt = 0;
    tick(2);
    rd(8'h50);
    chk(v, cnt);
    @(posedge clock);
    dbg <= 1'h0;
    w = cnt;
    // Off, then both reserved codes: the view must stay frozen in each.
    for (k = 0; k < 3; k++) begin
      wr(8'h40, (k == 0) ? 32'h0 : k * 32'h200 - 32'h100);
      tick(1);
      rd(8'h50);
      chk(v, w);
    end
    wr(8'h40, 32'h200);
    wr(8'h00, 32'h2);
    halt = 1;
    tick(2);
    rd(8'h50);
    chk(v, cnt);
    rd(8'h00);
    chk(v, 32'h60000);
    $display("prescale, debug and update test done");
    close_out();
  end
endmodule // tb_top

// ### rtl/rtc_count_core.v
`timescale 1ns/100ps
`include "rtc_count_map.vh"

module rtc_count_core (
  input wire clock,
  input wire rst_n,
  input wire [7:0] addr,
  input wire [31:0] wdata,
  input wire wr_stb,
  input wire rd_stb,
  output reg [31:0] rdata,
  input wire counter_clk_pin,
  input wire debug_halt_pin,
  output wire irq
);

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers: a change counts once stages two and three agree.
  reg [2:0] cclk_sync_q;
  reg [2:0] dbg_sync_q;
  reg cclk_level_q;
  reg dbg_level_q;
  wire cclk_edge;

  always @(posedge clock) begin
    if (!rst_n) begin
      cclk_sync_q <= 3'h0;
      dbg_sync_q <= 3'h0;
      cclk_level_q <= 1'b0;
      dbg_level_q <= 1'b0;
    end else begin
      cclk_sync_q <= {cclk_sync_q[1:0], counter_clk_pin};
      dbg_sync_q <= {dbg_sync_q[1:0], debug_halt_pin};
      if (cclk_sync_q[1] == cclk_sync_q[2]) begin
        cclk_level_q <= cclk_sync_q[2];
      end
      if (dbg_sync_q[1] == dbg_sync_q[2]) begin
        dbg_level_q <= dbg_sync_q[2];
      end
    end
  end

  assign cclk_edge = (cclk_sync_q[1] == cclk_sync_q[2]) && cclk_sync_q[2] && !cclk_level_q;

  ////////////////////////////////////////////////////////////////////////////
  // Registers.
  reg [31:0] count_q;
  reg [31:0] count_view_q;
  reg [31:0] wrap_shadow_q;
  reg [31:0] wrap_active_q;
  reg [31:0] alarm_shadow_q;
  reg [31:0] alarm_active_q;
  reg [3:0] prescale_q;
  reg [1:0] upd_mode_q;
  reg dbg_act_q;
  reg running_q;
  reg reset_busy_q;
  reg sys_ready_q;
  reg [1:0] status_q;
  reg [1:0] mask_q;
  reg [15:0] pre_q;

  wire wr_run = wr_stb && (addr == `ADDR_RUN_CONTROL);
  wire wr_cfg = wr_stb && (addr == `ADDR_COUNTER_CONFIG);
  wire wr_wrap = wr_stb && (addr == `ADDR_WRAP_LIMIT);
  wire wr_alarm = wr_stb && (addr == `ADDR_ALARM_COMPARE);
  wire wr_div = wr_stb && (addr == `ADDR_TICK_PRESCALE);
  wire wr_status = wr_stb && (addr == `ADDR_IRQ_STATUS);
  wire wr_mask = wr_stb && (addr == `ADDR_IRQ_MASK);
  wire start_req = wr_run && wdata[`BIT_START];
  wire stop_req = wr_run && wdata[`BIT_STOP];
  wire reset_req = wr_run && wdata[`BIT_CNT_RESET];

  ////////////////////////////////////////////////////////////////////////////
  // Tick divider and count step.
  wire [15:0] div_mask = ~(16'hFFFF << prescale_q);
  wire div_tick = cclk_edge && ((pre_q & div_mask) == div_mask);
  wire frozen = dbg_level_q && !dbg_act_q;
  wire step = div_tick && running_q && !frozen && !reset_busy_q;
  wire at_wrap = (count_q == wrap_active_q);
  wire [31:0] count_next = at_wrap ? 32'h00000000 : count_q + 32'h00000001;
  wire hit_upper = step && (count_next == wrap_active_q);
  wire hit_alarm = step && (count_next == alarm_active_q);

  always @(posedge clock) begin
    if (!rst_n) begin
      pre_q <= 16'h0000;
    end else if (reset_busy_q) begin
      pre_q <= 16'h0000;
    end else if (cclk_edge && running_q) begin
      pre_q <= pre_q + 16'h0001;
    end
  end

  // The counter reset takes one cycle; shadows load into the active copies
  // so new limits apply at once instead of waiting for the next wrap.
  always @(posedge clock) begin
    if (!rst_n) begin
      count_q <= 32'h00000000;
      wrap_active_q <= `LIMIT_RESET;
      alarm_active_q <= `LIMIT_RESET;
      reset_busy_q <= 1'b0;
      running_q <= 1'b0;
      sys_ready_q <= 1'b0;
    end else begin
      sys_ready_q <= 1'b1;
      reset_busy_q <= reset_req;
      if (reset_busy_q) begin
        count_q <= 32'h00000000;
        wrap_active_q <= wrap_shadow_q;
        alarm_active_q <= alarm_shadow_q;
      end else if (step) begin
        count_q <= count_next;
        if (at_wrap) begin
          wrap_active_q <= wrap_shadow_q;
          alarm_active_q <= alarm_shadow_q;
        end
      end
      if (stop_req) begin
        running_q <= 1'b0;
      end else if (start_req) begin
        running_q <= 1'b1;
      end
    end
  end

  // Auto-update copies every cycle; it is safe only when ticks are slow
  // relative to this clock, which is why software must choose it.
  always @(posedge clock) begin
    if (!rst_n) begin
      count_view_q <= 32'h00000000;
    end else if (reset_busy_q) begin
      count_view_q <= 32'h00000000;
    end else if (upd_mode_q == `UPD_AUTO) begin
      count_view_q <= count_q;
    end
  end

  always @(posedge clock) begin
    if (!rst_n) begin
      wrap_shadow_q <= `LIMIT_RESET;
      alarm_shadow_q <= `LIMIT_RESET;
      prescale_q <= 4'h0;
      upd_mode_q <= `UPD_OFF;
      dbg_act_q <= 1'b0;
      mask_q <= `MASK_RESET;
    end else begin
      if (wr_wrap) begin
        wrap_shadow_q <= wdata;
      end
      if (wr_alarm) begin
        alarm_shadow_q <= wdata;
      end
      if (wr_div) begin
        prescale_q <= wdata[`DIV_HI:`DIV_LO];
      end
      if (wr_cfg) begin
        upd_mode_q <= wdata[`UPD_MODE_HI:`UPD_MODE_LO];
        dbg_act_q <= wdata[`BIT_DBG_ACT];
      end
      if (wr_mask) begin
        mask_q <= {wdata[`BIT_UPPER], wdata[`BIT_ALARM]};
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sticky status: a new event beats a same-cycle write-one-to-clear.
  wire [1:0] events = {hit_upper, hit_alarm};
  wire [1:0] clr_bits = wr_status ? {wdata[`BIT_UPPER], wdata[`BIT_ALARM]} : 2'h0;

  always @(posedge clock) begin
    if (!rst_n) begin
      status_q <= 2'h0;
    end else begin
      status_q <= (status_q & ~clr_bits) | events;
    end
  end

  wire [1:0] masked = status_q & ~mask_q;
  assign irq = |masked;

  ////////////////////////////////////////////////////////////////////////////
  // Read port: data appear in the cycle after the strobe, else zero.
  reg [31:0] rd_d;

  always @* begin
    rd_d = 32'h00000000;
    if (addr == `ADDR_RUN_CONTROL) begin
      rd_d[`BIT_SYS_READY] = sys_ready_q;
      rd_d[`BIT_RESET_DONE] = sys_ready_q && !reset_busy_q;
      rd_d[`BIT_RUNNING] = running_q;
    end else if (addr == `ADDR_IRQ_STATUS) begin
      rd_d[`BIT_UPPER] = status_q[1];
      rd_d[`BIT_ALARM] = status_q[0];
    end else if (addr == `ADDR_IRQ_MASKED) begin
      rd_d[`BIT_UPPER] = masked[1];
      rd_d[`BIT_ALARM] = masked[0];
    end else if (addr == `ADDR_IRQ_MASK) begin
      rd_d[`BIT_UPPER] = mask_q[1];
      rd_d[`BIT_ALARM] = mask_q[0];
    end else if (addr == `ADDR_COUNTER_CONFIG) begin
      rd_d[`UPD_MODE_HI:`UPD_MODE_LO] = upd_mode_q;
      rd_d[`BIT_DBG_ACT] = dbg_act_q;
    end else if (addr == `ADDR_COUNT_VALUE) begin
      rd_d = count_view_q;
    end else if (addr == `ADDR_WRAP_LIMIT) begin
      rd_d = wrap_shadow_q;
    end else if (addr == `ADDR_ALARM_COMPARE) begin
      rd_d = alarm_shadow_q;
    end else if (addr == `ADDR_TICK_PRESCALE) begin
      rd_d[`DIV_HI:`DIV_LO] = prescale_q;
    end
  end

  always @(posedge clock) begin
    if (!rst_n) begin
      rdata <= 32'h00000000;
    end else if (rd_stb) begin
      rdata <= rd_d;
    end else begin
      rdata <= 32'h00000000;
    end
  end

endmodule // rtc_count_core

// ### rtl/rtc_count_map.vh
// Contract
// - Update mode 0 means off, 2 means auto; 1 and 3 reserved.
// - Readable count refreshes only as the update mode chooses; off never refreshes (a counter reset still zeroes the view in every mode).
// - Debug action 0 halts counting in debug mode; 1 ignores debug; resets 0.
// - Read-only count register shows the counter, resets to zero, ignores writes.
// - On reaching the active wrap limit the counter returns to zero next step.
// - An all-ones wrap limit gives a free-running full-range 32-bit counter.
// - Wrap limit writes go to a shadow, moved to active at each step that wraps the counter to zero.
// - A counter reset loads the shadowed wrap limit into the active limit.
// - Alarm writes go to a shadow, moved at the step that wraps the counter to zero or at counter reset.
// - Counting ticks divide the counter clock by two to the divider field.
// - Counter reset clears the count; reset-done reads 0 until it finishes.
// - Reaching the active alarm sets a write-one-to-clear status; mask gates interrupt.
// - Reaching the active limit sets a write-one-to-clear status; mask gates interrupt.
`ifndef RTC_COUNT_MAP_VH
`define RTC_COUNT_MAP_VH

`define ADDR_RUN_CONTROL 8'h00
`define ADDR_IRQ_STATUS 8'h20
`define ADDR_IRQ_MASKED 8'h24
`define ADDR_IRQ_MASK 8'h28
`define ADDR_COUNTER_CONFIG 8'h40
`define ADDR_COUNT_VALUE 8'h50
`define ADDR_WRAP_LIMIT 8'h60
`define ADDR_ALARM_COMPARE 8'h70
`define ADDR_TICK_PRESCALE 8'h80

`define BIT_START 0
`define BIT_STOP 1
`define BIT_CNT_RESET 2
`define BIT_RUNNING 16
`define BIT_RESET_DONE 17
`define BIT_SYS_READY 18
`define BIT_ALARM 15
`define BIT_UPPER 16
`define BIT_DBG_ACT 4
`define UPD_MODE_LO 8
`define UPD_MODE_HI 9
`define DIV_LO 8
`define DIV_HI 11

`define UPD_OFF 2'h0
`define UPD_AUTO 2'h2
`define LIMIT_RESET 32'hFFFFFFFF
`define MASK_RESET 2'h3

`endif
